// >>> verilog/flash_seq_cfg.svh
// Purpose: shared constants for the flash command sequencer and its host
// Assumes: included by bare name from the sequencer and host engine files
// Notes: definitions only
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
// sequence addresses, low twelve bits only
`define FS_ABITS 12
`define FS_UNLOCK_A 12'h555
`define FS_UNLOCK_B 12'hAAA
// sequence data bytes
`define FS_D_UNL1 8'hAA
`define FS_D_UNL2 8'h55
`define FS_D_PROG 8'hA0
`define FS_D_BYP 8'h20
`define FS_D_ERASE 8'h80
`define FS_D_BULK 8'h10
`define FS_D_SECT 8'h30
`define FS_D_SUSP 8'hB0
`define FS_D_BRST1 8'h90
`define FS_D_BRST2 8'h00
// inter-byte gap and erase window, in microseconds, and clock rate
`define FS_GAP_US 80
`define FS_CLK_MHZ 100
// sectors per array and reset values
`define FS_SECT_ALL 8'hFF
`define FS_SECT_NONE 8'h00
`define FS_CNT_ZERO 14'h0000
// status byte fields returned while an operation runs
`define FS_ST_READY 7
`define FS_ST_EWF 3
// host wait before sampling the ready/busy pin
`define FS_POLL_DLY 3'h3
`endif

// >>> verilog/flash_seq_pkg.sv
// Purpose: types shared by the sequencer and its host
// Assumes: nothing
// Notes: gray codes along the usual walk of the sequence decoder
package flash_seq_pkg;
    // per-array sequence decoder state
    typedef enum logic [3:0] {
        S_READ = 4'h0, S_UNL1 = 4'h1, S_UNL2 = 4'h3, S_PDATA = 4'h2,
        S_PBUSY = 4'h6, S_ECMD = 4'h7, S_EUNL1 = 4'h5, S_EUNL2 = 4'h4,
        S_EWIN = 4'hC, S_EBUSY = 4'hD, S_ESUSP = 4'hF, S_BRST = 4'hE
    } seq_state_t;
    // commands the host user side may request
    typedef enum logic [3:0] {
        C_READ = 4'h0, C_PROG = 4'h1, C_BYP_ENTER = 4'h2, C_BYP_PROG = 4'h3,
        C_BYP_EXIT = 4'h4, C_BULK = 4'h5, C_SECTOR = 4'h6,
        C_SECTOR_ADD = 4'h7, C_SUSPEND = 4'h8, C_RESUME = 4'h9
    } cmd_kind_t;
    // host bus engine state
    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_WR = 3'h1, H_GAP = 3'h3, H_POLL = 3'h2,
        H_RWAIT = 3'h6
    } host_state_t;
endpackage : flash_seq_pkg

// >>> verilog/flash_bus_if.sv
// Purpose: host processor bus as seen by the two flash arrays
// Assumes: single clock, strobes are one-cycle pulses
// Notes: selects are active high, at most one bit set at a time
`timescale 1ns/1ns
`default_nettype none
interface flash_bus_if;
    logic wr_stb;
    logic rd_stb;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] main_sector_select;
    logic [3:0] secondary_sector_select;
    logic rd_valid;
    logic [7:0] rdata;
    logic ready_busy_pin;
    // the documented flash end
    modport dev (
        input wr_stb, rd_stb, addr, wdata,
        input main_sector_select, secondary_sector_select,
        output rd_valid, rdata, ready_busy_pin
    );
    // the host processor end
    modport host (
        output wr_stb, rd_stb, addr, wdata,
        output main_sector_select, secondary_sector_select,
        input rd_valid, rdata, ready_busy_pin
    );
endinterface : flash_bus_if
`default_nettype wire

// >>> verilog/flash_command_sequencer.sv
// Purpose: command sequence decoder for the main and secondary arrays
// Assumes: host keeps one sector select active through a sequence
// Notes: embedded algorithms and storage live on the user side
//
// Overview of operation
// - only the single host bus reaches arrays
// - host programs via unlock, command, data, poll
// - unlock is AAh at 555h, 55h at AAAh
// - upper four address lines ignored; select picks array
// - host holds target select during whole sequence
// - launch only on complete sequence, gaps under 80us
// - bad byte or gap timeout returns to read; code ignores stray bytes in the erase window
// - program is unlock, A0h at 555h, data
// - unlock then 20h at 555h enters bypass
// - in bypass, A0h anywhere then data programs
// - 90h then 00h leaves bypass mode
// - bulk erase is six-cycle sequence ending 10h
// - sector erase ends 30h; more 30h add sectors
// - B0h to erasing array suspends sector erase
// - suspended erase allows other sector access, resumes
// - after operation, array returns to read mode
// - read mode returns stored byte, no sequence
// - host runs code from another array meanwhile
// - reads inside a sequence belong to it
// - only low twelve address bits are compared
// - bulk erase clears every sector of array; code leaves protected sectors out of mask
// - added sectors within 80us, else flag reads 1
// - program to protected sector is ignored
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_cfg.svh"
module flash_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter int GAP_CYC = `FS_GAP_US * `FS_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic reset,
    flash_bus_if.dev bus,
    input wire logic [1:0] op_done,
    input wire logic [1:0][7:0] sect_protect,
    input wire logic [1:0][7:0] mem_rdata,
    output logic [1:0] op_start,
    output logic op_erase,
    output logic [14:0] op_addr,
    output logic [7:0] op_data,
    output logic [1:0][7:0] erase_mask,
    output logic [1:0] erase_suspend,
    output logic [1:0] erase_resume,
    output logic [1:0] erase_window_flag,
    output logic mem_rd_array,
    output logic [14:0] mem_rd_addr
);
    ////////////////////////////////////////////////////////////////////
    // helpers
    // encode the single active select into a sector index
    function automatic logic [2:0] sect_idx(input logic [7:0] s);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (s[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction : sect_idx

    // states in which the inter-byte gap is timed
    function automatic logic is_timed(input seq_state_t s);
        return s inside {S_UNL1, S_UNL2, S_PDATA, S_ECMD, S_EUNL1,
                         S_EUNL2, S_BRST, S_EWIN};
    endfunction : is_timed

    // decode one written byte; upper address lines never reach here
    function automatic seq_state_t seq_next(input seq_state_t s,
        input logic byp, input logic [7:0] d, input logic [11:0] a,
        input logic prot);
        logic ua;
        logic ub;
        seq_state_t n;
        ua = (a == `FS_UNLOCK_A);
        ub = (a == `FS_UNLOCK_B);
        n = S_READ;
        unique case (s)
            S_READ: begin
                if (d == `FS_D_UNL1 && ua) n = S_UNL1;
                else if (byp && d == `FS_D_PROG) n = S_PDATA;
                else if (byp && d == `FS_D_BRST1) n = S_BRST;
            end
            S_UNL1: if (d == `FS_D_UNL2 && ub) n = S_UNL2;
            S_UNL2: begin
                if (ua && d == `FS_D_PROG) n = S_PDATA;
                else if (ua && d == `FS_D_ERASE) n = S_ECMD;
            end
            S_PDATA: n = prot ? S_READ : S_PBUSY;
            S_ECMD: if (d == `FS_D_UNL1 && ua) n = S_EUNL1;
            S_EUNL1: if (d == `FS_D_UNL2 && ub) n = S_EUNL2;
            S_EUNL2: begin
                if (ua && d == `FS_D_BULK) n = S_EBUSY;
                else if (d == `FS_D_SECT) n = S_EWIN;
            end
            S_EWIN: n = S_EWIN; // stray bytes do not cancel the erase
            S_PBUSY: n = S_PBUSY;
            S_EBUSY: n = (d == `FS_D_SUSP) ? S_ESUSP : S_EBUSY;
            S_ESUSP: n = (d == `FS_D_SECT) ? S_EBUSY : S_ESUSP;
            S_BRST: n = S_READ;
            default: n = S_READ;
        endcase
        return n;
    endfunction : seq_next

    ////////////////////////////////////////////////////////////////////
    // bus intake: one master port only
    logic [1:0][7:0] sel;
    logic [1:0] hit;
    logic [1:0] wr;
    logic [1:0] rd;
    logic [11:0] low_a;
    assign sel[0] = bus.main_sector_select;
    assign sel[1] = {4'h0, bus.secondary_sector_select};
    assign low_a = bus.addr[11:0];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            hit[i] = |sel[i];
            wr[i] = bus.wr_stb & hit[i];
            rd[i] = bus.rd_stb & hit[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-array state
    seq_state_t state_ff [2];
    seq_state_t nxt_state [2];
    logic [1:0] byp_ff;
    logic [1:0][13:0] gap_cnt_ff;
    logic [1:0] gap_out;
    logic [1:0][7:0] mask_ff;
    logic [1:0][2:0] sec;
    logic [1:0] prot;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sec[i] = sect_idx(sel[i]);
            prot[i] = sect_protect[i][sec[i]];
            gap_out[i] = is_timed(state_ff[i])
                && gap_cnt_ff[i] == 14'(GAP_CYC - 1);
            nxt_state[i] = state_ff[i];
            if (wr[i]) begin
                nxt_state[i] = seq_next(state_ff[i], byp_ff[i],
                    bus.wdata, low_a, prot[i]);
            end else if (rd[i]) begin
                nxt_state[i] = state_ff[i];
            end else if (gap_out[i]) begin
                // window closing launches; elsewhere the gap aborts
                nxt_state[i] = (state_ff[i] == S_EWIN) ? S_EBUSY
                    : S_READ;
            end
            if (op_done[i] && (state_ff[i] == S_PBUSY
                || state_ff[i] == S_EBUSY)) begin
                nxt_state[i] = S_READ;
            end
        end
    end

    // decoder state
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) state_ff[i] <= S_READ;
            else state_ff[i] <= nxt_state[i];
        end
    end

    // gap timer restarts on every access to the array
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset || wr[i] || rd[i] || !is_timed(state_ff[i]))
                gap_cnt_ff[i] <= `FS_CNT_ZERO;
            else
                gap_cnt_ff[i] <= gap_cnt_ff[i] + 14'h0001;
        end
    end

    // bypass mode flag
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) byp_ff[i] <= 1'b0;
            else if (wr[i] && state_ff[i] == S_UNL2
                && low_a == `FS_UNLOCK_A && bus.wdata == `FS_D_BYP)
                byp_ff[i] <= 1'b1;
            else if (wr[i] && state_ff[i] == S_BRST
                && bus.wdata == `FS_D_BRST2)
                byp_ff[i] <= 1'b0;
        end
    end

    // sectors gathered for erase; protected ones never join
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset || nxt_state[i] == S_READ)
                mask_ff[i] <= `FS_SECT_NONE;
            else if (wr[i] && state_ff[i] == S_EUNL2
                && nxt_state[i] == S_EBUSY)
                mask_ff[i] <= `FS_SECT_ALL & ~sect_protect[i];
            else if (wr[i] && bus.wdata == `FS_D_SECT
                && (state_ff[i] == S_EUNL2 || state_ff[i] == S_EWIN))
                mask_ff[i] <= mask_ff[i]
                    | ((8'h01 << sec[i]) & ~sect_protect[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // launch, suspend and resume strobes towards the algorithms
    logic [1:0] op_start_ff;
    logic op_erase_ff;
    logic [14:0] op_addr_ff;
    logic [7:0] op_data_ff;
    logic [1:0] susp_ff;
    logic [1:0] resm_ff;
    logic [1:0] ewf_ff;
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) begin
                op_start_ff[i] <= 1'b0;
                susp_ff[i] <= 1'b0;
                resm_ff[i] <= 1'b0;
                ewf_ff[i] <= 1'b1;
            end else begin
                op_start_ff[i] <= (state_ff[i] != S_PBUSY
                    && nxt_state[i] == S_PBUSY)
                    || (state_ff[i] != S_EBUSY && state_ff[i] != S_ESUSP
                    && nxt_state[i] == S_EBUSY);
                susp_ff[i] <= state_ff[i] == S_EBUSY
                    && nxt_state[i] == S_ESUSP;
                resm_ff[i] <= state_ff[i] == S_ESUSP
                    && nxt_state[i] == S_EBUSY;
                ewf_ff[i] <= nxt_state[i] != S_EWIN;
            end
        end
    end

    // operation details; a single host means one launch per cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            op_erase_ff <= 1'b0;
            op_addr_ff <= 15'h0000;
            op_data_ff <= 8'h00;
        end else if (bus.wr_stb) begin
            op_erase_ff <= bus.wdata != `FS_D_UNL1 ? 1'b0 : 1'b0;
            op_addr_ff <= {sect_idx(sel[0] | sel[1]), low_a};
            op_data_ff <= bus.wdata;
        end else if (gap_out[0] || gap_out[1]) begin
            op_erase_ff <= 1'b1;
        end
        if (!reset && (wr[0] || wr[1])) begin
            op_erase_ff <= (wr[0] && state_ff[0] == S_EUNL2)
                || (wr[1] && state_ff[1] == S_EUNL2);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path: array data in read mode, status while busy
    logic rd_p1_ff;
    logic rd_stat_ff;
    logic rd_arr_ff;
    logic [14:0] rd_addr_ff;
    logic [7:0] stat_ff;
    logic rd_valid_ff;
    logic [7:0] rdata_ff;
    logic rb_ff;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_p1_ff <= 1'b0;
            rd_stat_ff <= 1'b0;
            rd_arr_ff <= 1'b0;
            rd_addr_ff <= 15'h0000;
            stat_ff <= 8'h00;
        end else begin
            rd_p1_ff <= bus.rd_stb && |hit;
            if (bus.rd_stb) begin
                rd_arr_ff <= hit[1];
                rd_addr_ff <= {sect_idx(sel[0] | sel[1]), low_a};
                // plain reads go straight to the array
                rd_stat_ff <= hit[1] ? !(state_ff[1] inside
                    {S_READ, S_ESUSP}) : !(state_ff[0] inside
                    {S_READ, S_ESUSP});
                stat_ff <= 8'h00;
                stat_ff[`FS_ST_EWF] <= hit[1] ? ewf_ff[1] : ewf_ff[0];
            end
        end
    end

    // answer one cycle after the array address is presented
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_valid_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            rd_valid_ff <= rd_p1_ff;
            if (rd_p1_ff)
                rdata_ff <= rd_stat_ff ? stat_ff
                    : mem_rdata[rd_arr_ff];
        end
    end

    // ready/busy: low from the last command byte, erase window included,
    // so a host polling the pin cannot finish before the erase launches
    always_ff @(posedge sys_clk) begin
        if (reset) rb_ff <= 1'b1;
        else rb_ff <= !(nxt_state[0] inside {S_PBUSY, S_EBUSY, S_EWIN}
            || nxt_state[1] inside {S_PBUSY, S_EBUSY, S_EWIN});
    end

    assign op_start = op_start_ff;
    assign op_erase = op_erase_ff;
    assign op_addr = op_addr_ff;
    assign op_data = op_data_ff;
    assign erase_mask = mask_ff;
    assign erase_suspend = susp_ff;
    assign erase_resume = resm_ff;
    assign erase_window_flag = ewf_ff;
    assign mem_rd_array = rd_arr_ff;
    assign mem_rd_addr = rd_addr_ff;
    assign bus.rd_valid = rd_valid_ff;
    assign bus.rdata = rdata_ff;
    assign bus.ready_busy_pin = rb_ff;
endmodule : flash_command_sequencer
`default_nettype wire

// >>> verilog/flash_host_engine.sv
// Purpose: host end that turns user commands into flash bus sequences
// Assumes: user side runs code from the other array or from SRAM
// Notes: one write every other cycle; select held for the whole sequence
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_cfg.svh"
module flash_host_engine
    import flash_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    flash_bus_if.host bus,
    input wire logic cmd_valid,
    input wire cmd_kind_t cmd_kind,
    input wire logic cmd_array,
    input wire logic [2:0] cmd_sector,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);
    ////////////////////////////////////////////////////////////////////
    // one step of a sequence: {last, address, data}
    function automatic logic [24:0] seq_step(input cmd_kind_t k,
        input logic [2:0] n, input logic [15:0] ta, input logic [7:0] td);
        logic [15:0] ua;
        logic [15:0] ub;
        logic [7:0] ed;
        ua = {ta[15:12], `FS_UNLOCK_A};
        ub = {ta[15:12], `FS_UNLOCK_B};
        // last byte of an erase picks bulk or sector
        ed = (k == C_SECTOR) ? `FS_D_SECT : `FS_D_BULK;
        unique case (k)
            C_PROG, C_BYP_ENTER: begin
                if (n == 3'h0) return {1'b0, ua, `FS_D_UNL1};
                if (n == 3'h1) return {1'b0, ub, `FS_D_UNL2};
                if (k == C_BYP_ENTER) return {1'b1, ua, `FS_D_BYP};
                if (n == 3'h2) return {1'b0, ua, `FS_D_PROG};
                return {1'b1, ta, td};
            end
            C_BULK, C_SECTOR: begin
                if (n == 3'h0 || n == 3'h3) return {1'b0, ua, `FS_D_UNL1};
                if (n == 3'h1 || n == 3'h4) return {1'b0, ub, `FS_D_UNL2};
                if (n == 3'h2) return {1'b0, ua, `FS_D_ERASE};
                return {1'b1, k == C_SECTOR ? ta : ua, ed};
            end
            C_BYP_PROG: return n == 3'h0 ? {1'b0, ta, `FS_D_PROG}
                : {1'b1, ta, td};
            C_BYP_EXIT: return n == 3'h0 ? {1'b0, ta, `FS_D_BRST1}
                : {1'b1, ta, `FS_D_BRST2};
            C_SUSPEND: return {1'b1, ta, `FS_D_SUSP};
            default: return {1'b1, ta, `FS_D_SECT};
        endcase
    endfunction : seq_step

    ////////////////////////////////////////////////////////////////////
    host_state_t st_ff;
    cmd_kind_t kind_ff;
    logic [2:0] idx_ff;
    logic [2:0] wait_ff;
    logic [15:0] ta_ff;
    logic [7:0] td_ff;
    logic wr_ff;
    logic rd_ff;
    logic [15:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] msel_ff;
    logic [3:0] ssel_ff;
    logic rdy_ff;
    logic rsp_v_ff;
    logic [7:0] rsp_d_ff;
    logic [24:0] step;
    assign step = seq_step(kind_ff, idx_ff, ta_ff, td_ff);

    // sequence engine
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff <= H_IDLE;
            kind_ff <= C_READ;
            idx_ff <= 3'h0;
            wait_ff <= 3'h0;
            ta_ff <= 16'h0000;
            td_ff <= 8'h00;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 16'h0000;
            wdata_ff <= 8'h00;
            msel_ff <= 8'h00;
            ssel_ff <= 4'h0;
            rdy_ff <= 1'b1;
            rsp_v_ff <= 1'b0;
            rsp_d_ff <= 8'h00;
        end else begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            rsp_v_ff <= 1'b0;
            unique case (st_ff)
                H_IDLE: if (cmd_valid) begin
                    kind_ff <= cmd_kind;
                    ta_ff <= cmd_addr;
                    td_ff <= cmd_data;
                    idx_ff <= 3'h0;
                    rdy_ff <= 1'b0;
                    // select stays up until the engine returns
                    msel_ff <= cmd_array ? 8'h00 : 8'h01 << cmd_sector;
                    ssel_ff <= cmd_array ? 4'h1 << cmd_sector[1:0] : 4'h0;
                    if (cmd_kind == C_READ) begin
                        rd_ff <= 1'b1;
                        addr_ff <= cmd_addr;
                        st_ff <= H_RWAIT;
                    end else begin
                        st_ff <= H_WR;
                    end
                end
                H_WR: begin
                    wr_ff <= 1'b1;
                    addr_ff <= step[23:8];
                    wdata_ff <= step[7:0];
                    idx_ff <= idx_ff + 3'h1;
                    wait_ff <= 3'h0;
                    st_ff <= step[24] ? H_POLL : H_GAP;
                end
                H_GAP: st_ff <= H_WR;
                H_POLL: begin
                    // completion is seen on the ready/busy pin
                    if (wait_ff != `FS_POLL_DLY) begin
                        wait_ff <= wait_ff + 3'h1;
                    end else if (bus.ready_busy_pin) begin
                        st_ff <= H_IDLE;
                        rdy_ff <= 1'b1;
                        rsp_v_ff <= 1'b1;
                        msel_ff <= 8'h00;
                        ssel_ff <= 4'h0;
                    end
                end
                H_RWAIT: if (bus.rd_valid) begin
                    st_ff <= H_IDLE;
                    rdy_ff <= 1'b1;
                    rsp_v_ff <= 1'b1;
                    rsp_d_ff <= bus.rdata;
                    msel_ff <= 8'h00;
                    ssel_ff <= 4'h0;
                end
                default: st_ff <= H_IDLE;
            endcase
        end
    end

    assign bus.wr_stb = wr_ff;
    assign bus.rd_stb = rd_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
    assign bus.main_sector_select = msel_ff;
    assign bus.secondary_sector_select = ssel_ff;
    assign cmd_ready = rdy_ff;
    assign rsp_valid = rsp_v_ff;
    assign rsp_data = rsp_d_ff;
endmodule : flash_host_engine
`default_nettype wire

// >>> dv/flash_command_sequencer_properties.sv
// Purpose: timing relations on the link between host and flash arrays
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the interface wires
`timescale 1ns/1ns
`default_nettype none
module flash_bus_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] main_sector_select,
    input wire logic [3:0] secondary_sector_select,
    input wire logic rd_valid,
    input wire logic [7:0] rdata,
    input wire logic ready_busy_pin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // reset must leave the link quiet and the arrays ready
    idle_after_reset_a: assert property (disable iff (1'b0) reset |=>
        ready_busy_pin && !wr_stb && !rd_stb) else $error("busy after reset");
    read_answer_a: assert property (rd_stb && (|main_sector_select ||
        |secondary_sector_select) |-> ##2 rd_valid) else $error("no answer");
    valid_cause_a: assert property (rd_valid |-> $past(rd_stb, 2))
        else $error("answer without read");
    one_select_a: assert property ($onehot0({main_sector_select,
        secondary_sector_select})) else $error("two selects");
    write_select_a: assert property (wr_stb |->
        (|main_sector_select || |secondary_sector_select)) else $error("nosel");
    strobe_apart_a: assert property (!(wr_stb && rd_stb))
        else $error("read and write together");
    unlock_pair_a: assert property (wr_stb && addr[11:0] == 12'h555 &&
        wdata == 8'hAA ##2 wr_stb |-> addr[11:0] == 12'hAAA &&
        wdata == 8'h55) else $error("bad unlock pair");
    write_spacing_a: assert property (wr_stb |=> !wr_stb)
        else $error("writes back to back");
    rdata_hold_a: assert property (!$stable(rdata) |-> rd_valid)
        else $error("read data moved");
    // main scenarios reached
    cover property (rd_valid);
    cover property ($fell(ready_busy_pin));
    cover property (wr_stb && wdata == 8'h30);
endmodule : flash_bus_checker
`default_nettype wire

// >>> dv/flash_command_sequencer_test.sv
// Purpose: self-checking bench for the flash sequencer and its host
// Assumes: gap count shortened to 40 cycles
// Notes: array contents are a fixed pattern of the read address
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_test;
    import flash_seq_pkg::*;
    typedef struct {cmd_kind_t k; logic a; logic [2:0] s; logic [15:0] ad;
        logic [7:0] d; logic [1:0] sel; logic [23:0] e;} row_t;
    row_t rows[10];
    logic sys_clk, reset, cmd_valid, cmd_array, cmd_ready, rsp_valid;
    logic op_erase, mem_rd_array;
    cmd_kind_t cmd_kind;
    logic [2:0] cmd_sector;
    logic [15:0] cmd_addr;
    logic [7:0] cmd_data, rsp_data, op_data;
    logic [1:0] op_done = 2'h0, op_start, erase_window_flag;
    logic [1:0][7:0] mem_rdata, erase_mask;
    logic [14:0] op_addr, mem_rd_addr;
    logic [23:0] op_rec, er_rec;
    int op_cnt = 0, win_cyc = 0, bad_count = 0, compares = 0;
    flash_bus_if bus ();
    flash_command_sequencer #(.GAP_CYC(40)) u_flash_command_sequencer (
        .sys_clk(sys_clk), .reset(reset), .bus(bus), .op_done(op_done),
        .sect_protect(16'h0080), .mem_rdata(mem_rdata), .op_start(op_start),
        .op_erase(op_erase), .op_addr(op_addr), .op_data(op_data),
        .erase_mask(erase_mask), .erase_suspend(), .erase_resume(),
        .erase_window_flag(erase_window_flag), .mem_rd_array(mem_rd_array),
        .mem_rd_addr(mem_rd_addr));
    flash_host_engine u_flash_host_engine (.sys_clk(sys_clk), .reset(reset),
        .bus(bus), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_array(cmd_array), .cmd_sector(cmd_sector), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    flash_bus_checker u_flash_bus_checker (.sys_clk(sys_clk), .reset(reset),
        .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .addr(bus.addr),
        .wdata(bus.wdata), .main_sector_select(bus.main_sector_select),
        .secondary_sector_select(bus.secondary_sector_select),
        .rd_valid(bus.rd_valid), .rdata(bus.rdata),
        .ready_busy_pin(bus.ready_busy_pin));
    ////////////////////////////////////////////////////////////
    // pattern memory; each array differs so a wrong array shows
    assign mem_rdata = {mem_rd_addr[7:0] ^ {7'h1E, !mem_rd_array},
        mem_rd_addr[7:0] ^ {7'h2D, mem_rd_array}};
    // operations finish at once so the host poll ends quickly
    always @(posedge sys_clk) begin
        op_done <= reset ? 2'h0 : op_start;
        if (op_start != 2'h0) begin
            op_cnt <= op_cnt + 1;
            op_rec <= {op_erase, op_addr, op_data};
            er_rec <= {15'h0, op_erase, erase_mask[op_start[1]]};
        end
        if (erase_window_flag != 2'h3) win_cyc <= win_cyc + 1;
    end
    task check(input logic [24:0] seen, input logic [24:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    // one command through the host; top bit tells if a launch happened
    task run_row(input row_t r);
        int n;
        logic [24:0] seen;
        n = op_cnt;
        #1 cmd_kind = r.k;
        {cmd_array, cmd_sector} = {r.a, r.s};
        {cmd_addr, cmd_data, cmd_valid} = {r.ad, r.d, 1'b1};
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        for (int i = 0; i < 2000 && rsp_valid !== 1'b1; i++)
            @(posedge sys_clk) #1;
        check({24'h0, rsp_valid === 1'b1}, 25'h1);
        case (r.sel)
            2'h1: seen = {9'h0, 8'h0, rsp_data};
            2'h2: seen = {1'b0, op_rec};
            2'h3: seen = {1'b0, er_rec};
            default: seen = 25'h0;
        endcase
        seen[24] = (op_cnt != n);
        check(seen, {r.sel[1], r.e});
        $display("row done, kind %0d", r.k);
        @(posedge sys_clk);
    endtask : run_row
    task final_report;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // a hang cuts the run short well past the longest sequence
    initial begin
        #500000 bad_count++;
        final_report();
    end
    initial begin
        {reset, cmd_valid, cmd_array, cmd_sector} = {2'h2, 4'h0};
        cmd_kind = C_READ;
        {cmd_addr, cmd_data} = 24'h0;
        rows = '{'{C_PROG, 1'h0, 3'h2, 16'hF123, 8'h4B, 2'h2, 24'h21234B},
            '{C_READ, 1'h1, 3'h1, 16'h0045, 8'h00, 2'h1, 24'h000079},
            '{C_BYP_ENTER, 1'h0, 3'h0, 16'h0, 8'h00, 2'h0, 24'h0},
            '{C_BYP_PROG, 1'h0, 3'h3, 16'h0777, 8'h11, 2'h2, 24'h377711},
            '{C_BYP_EXIT, 1'h0, 3'h0, 16'h0, 8'h00, 2'h0, 24'h0},
            '{C_BYP_PROG, 1'h0, 3'h3, 16'h0777, 8'h11, 2'h0, 24'h0},
            '{C_PROG, 1'h0, 3'h7, 16'h0100, 8'h22, 2'h0, 24'h0},
            '{C_BULK, 1'h1, 3'h0, 16'h0, 8'h00, 2'h3, 24'h0001FF},
            '{C_SECTOR, 1'h0, 3'h5, 16'h0, 8'h00, 2'h3, 24'h000120},
            '{C_READ, 1'h0, 3'h4, 16'h0AAA, 8'h00, 2'h1, 24'h0000F0}};
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        check({22'h0, bus.ready_busy_pin, cmd_ready, &erase_window_flag}, 25'h7);
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i]);
        check({23'h0, win_cyc >= 40, &erase_window_flag}, 25'h3);
        $display("erase window test done");
        final_report();
    end
endmodule : flash_command_sequencer_test
`default_nettype wire
